// File: verilog/dasp_port.sv
// audio serial port: transmit fifo, framing engine, master/slave timing
`timescale 1ns/1ps

module dasp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic in_ready_r;
    wire push = in_valid & in_ready_r;
    wire pop = out_valid & out_ready;
    wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    wire [AW-1:0] wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
    wire [AW-1:0] rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;

    assign in_ready = in_ready_r;
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready_r <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_nxt;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_nxt;
            end
            count_r <= count_nxt;
            in_ready_r <= (count_nxt != FULL);
        end
    end
endmodule

module dasp_port (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cfg_master,
    input wire logic cfg_normal_mode,
    input wire logic cfg_sync_two,
    input wire logic cfg_dual_mono,
    input wire dasp_pkg::dasp_rate_t cfg_rate,
    input wire logic [dasp_pkg::WORD_BITS-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [dasp_pkg::WORD_BITS-1:0] rx_data,
    output logic rx_valid,
    output logic rx_chan,
    output logic tx_underrun,
    output logic serial_data_out,
    input wire logic serial_data_in,
    input wire logic bit_clk_i,
    output logic bit_clk_o,
    output logic bit_clk_oe,
    input wire logic word_align_sync_i,
    output logic word_align_sync_o,
    output logic word_align_sync_oe
);
    import dasp_pkg::*;

    // {data bit, first bit of word, last bit of word}
    function automatic logic [2:0] win(input logic [5:0] cnt,
        input logic normal, input logic [5:0] sl, input logic dual);
        logic hi;
        hi = dual & (cnt >= HALF_NORMAL) & (cnt < LEN_NORMAL);
        if (normal) begin
            return {(cnt < HALF_NORMAL) | hi,
                (cnt == CNT_RST) | (dual & (cnt == HALF_NORMAL)),
                (cnt == WORD_LAST) | (dual & (cnt == LEN_NORMAL - 6'h01))};
        end
        return {(cnt >= sl) & (cnt < sl + HALF_NORMAL), cnt == sl,
            cnt == sl + WORD_LAST};
    endfunction

    logic bclk_s1_r, bclk_s2_r, bclk_s3_r;
    logic ws_s1_r, ws_s2_r, ws_prev_r;
    logic rxd_s1_r, rxd_s2_r;
    logic [NCO_BITS-1:0] acc_r;
    logic [5:0] cnt_r;
    logic [WORD_BITS-1:0] tx_sh_r, rx_sh_r, rx_data_r;
    logic bclk_o_r, bclk_oe_r, ws_o_r, ws_oe_r, txd_r;
    logic rx_valid_r, rx_chan_r, underrun_r;
    logic [WORD_BITS-1:0] f_data;
    logic f_valid;

    wire [5:0] len_w = cfg_normal_mode ? LEN_NORMAL :
        (cfg_sync_two ? LEN_PCM_TWO : LEN_PCM_ONE);
    wire [5:0] sync_len_w = cfg_sync_two ? SYNC_TWO : SYNC_ONE;
    wire [NCO_BITS-1:0] inc_w = dasp_nco_inc(cfg_rate, len_w);
    wire [NCO_BITS:0] acc_sum_w = {1'b0, acc_r} + {1'b0, inc_w};
    wire tick_w = cfg_master & acc_sum_w[NCO_BITS];
    wire rise_ev = cfg_master ? (tick_w & ~bclk_o_r) :
        (bclk_s2_r & ~bclk_s3_r);
    wire fall_ev = cfg_master ? (tick_w & bclk_o_r) :
        (~bclk_s2_r & bclk_s3_r);
    wire ws_rise_w = ~cfg_master & rise_ev & ws_s2_r & ~ws_prev_r;
    wire cnt_last_w = (cnt_r >= len_w - 6'h01);
    wire [5:0] cnt_adv = cnt_last_w ? CNT_RST : cnt_r + 6'h01;
    wire [5:0] cnt_rx = ws_rise_w ? CNT_RST : cnt_r;
    wire [2:0] tx_win = win(cnt_adv, cfg_normal_mode, sync_len_w,
        cfg_dual_mono);
    wire [2:0] rx_win = win(cnt_rx, cfg_normal_mode, sync_len_w,
        cfg_dual_mono);
    wire ws_gen_w = cfg_normal_mode ? (cnt_adv < HALF_NORMAL) :
        (cnt_adv < sync_len_w);
    wire pop_w = fall_ev & tx_win[1] & f_valid;
    // an empty fifo at word start sends silence rather than stale data
    wire [WORD_BITS-1:0] tx_word_w = f_valid ? f_data : WORD_RST;

    dasp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(pop_w)
    );

    assign bit_clk_o = bclk_o_r;
    assign bit_clk_oe = bclk_oe_r;
    assign word_align_sync_o = ws_o_r;
    assign word_align_sync_oe = ws_oe_r;
    assign serial_data_out = txd_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;
    assign rx_chan = rx_chan_r;
    assign tx_underrun = underrun_r;

    // pins are asynchronous; only the second stage, and the bit clock's third for its edges, is looked at
    always_ff @(posedge clock) begin
        bclk_s1_r <= bit_clk_i;
        bclk_s2_r <= bclk_s1_r;
        // no reset here, so no false edge when reset lets go
        bclk_s3_r <= bclk_s2_r;
        ws_s1_r <= word_align_sync_i;
        ws_s2_r <= ws_s1_r;
        rxd_s1_r <= serial_data_in;
        rxd_s2_r <= rxd_s1_r;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_r <= NCO_RST;
            bclk_o_r <= 1'b0;
            bclk_oe_r <= 1'b0;
            ws_oe_r <= 1'b0;
        end else begin
            // fractional divider: jitter of one clock, exact average rate
            acc_r <= cfg_master ? acc_sum_w[NCO_BITS-1:0] :
                NCO_RST;
            bclk_o_r <= cfg_master & (bclk_o_r ^ tick_w);
            bclk_oe_r <= cfg_master;
            ws_oe_r <= cfg_master;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_r <= CNT_RST;
            ws_o_r <= 1'b0;
            ws_prev_r <= 1'b0;
            txd_r <= 1'b0;
            tx_sh_r <= WORD_RST;
            underrun_r <= 1'b0;
        end else if (fall_ev) begin
            cnt_r <= cnt_adv;
            ws_o_r <= cfg_master & ws_gen_w;
            underrun_r <= tx_win[1] & ~f_valid;
            if (tx_win[1]) begin
                txd_r <= tx_word_w[WORD_BITS-1];
                tx_sh_r <= {tx_word_w[WORD_BITS-2:0], 1'b0};
            end else begin
                txd_r <= tx_win[2] & tx_sh_r[WORD_BITS-1];
                tx_sh_r <= {tx_sh_r[WORD_BITS-2:0], 1'b0};
            end
        end else if (rise_ev) begin
            ws_prev_r <= ws_s2_r;
            underrun_r <= 1'b0;
            if (ws_rise_w) begin
                cnt_r <= CNT_RST;
            end
        end else begin
            underrun_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_sh_r <= WORD_RST;
            rx_data_r <= WORD_RST;
            rx_valid_r <= 1'b0;
            rx_chan_r <= 1'b0;
        end else begin
            rx_valid_r <= rise_ev & rx_win[2] & rx_win[0];
            if (rise_ev & rx_win[2]) begin
                rx_sh_r <= {rx_sh_r[WORD_BITS-2:0], rxd_s2_r};
            end
            if (rise_ev & rx_win[2] & rx_win[0]) begin
                rx_data_r <= {rx_sh_r[WORD_BITS-2:0], rxd_s2_r};
                rx_chan_r <= cfg_normal_mode & (cnt_rx >= HALF_NORMAL);
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    role_drive_a: assert property (!$past(sys_rst)
        |-> bclk_oe_r == $past(cfg_master))
        else $error("bit clock enable does not follow role");
    sync_drive_a: assert property (ws_oe_r == bclk_oe_r)
        else $error("sync enable differs from clock enable");
    slave_quiet_a: assert property (!bclk_oe_r |-> !bit_clk_o)
        else $error("bit clock toggles in slave role");
    pcm_sync_a: assert property (
        cfg_master && !cfg_normal_mode && fall_ev
        |=> ws_o_r == (cnt_r < $past(sync_len_w)))
        else $error("short sync pulse has wrong length");
    long_sync_a: assert property (
        cfg_master && cfg_normal_mode && fall_ev
        |=> ws_o_r == (cnt_r < HALF_NORMAL))
        else $error("long sync not half high half low");
    frame_wrap_a: assert property (fall_ev && cnt_r == len_w - 6'h01
        |=> cnt_r == CNT_RST)
        else $error("frame does not wrap at its length");
    frame_len_a: assert property (fall_ev && cnt_last_w |->
        cnt_r == (cfg_normal_mode ? 6'h1f : (cfg_sync_two ? 6'h11 : 6'h10)))
        else $error("frame length wrong for mode");
    msb_first_a: assert property (fall_ev && tx_win[1] && f_valid
        |=> txd_r == $past(f_data[WORD_BITS-1]))
        else $error("first bit sent is not the msb");
    rx_pulse_a: assert property (rx_valid_r |=> !rx_valid_r)
        else $error("receive strobe longer than one cycle");
    edge_sep_a: assert property (cfg_master && rise_ev
        |=> !rise_ev ##1 !rise_ev)
        else $error("master bit clock edges too close");

    wrap_c: cover property (cfg_master && fall_ev && cnt_last_w);
    slave_rx_c: cover property (!cfg_master && rx_valid_r);
    dual_c: cover property (rx_valid_r && rx_chan_r);
    underrun_c: cover property (underrun_r);
    full_c: cover property (!tx_ready && tx_valid);
endmodule

// File: verilog/dasp_pkg.sv
// constants, sample-rate codes and divider helper for the audio serial port
package dasp_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int WORD_BITS = 16;
    localparam int NCO_BITS = 32;
    localparam int FIFO_DEPTH = 4;
    localparam logic [5:0] LEN_NORMAL = 6'h20;
    localparam logic [5:0] LEN_PCM_ONE = 6'h11;
    localparam logic [5:0] LEN_PCM_TWO = 6'h12;
    localparam logic [5:0] HALF_NORMAL = 6'h10;
    localparam logic [5:0] SYNC_ONE = 6'h01;
    localparam logic [5:0] SYNC_TWO = 6'h02;
    localparam logic [5:0] WORD_LAST = 6'h0f;
    localparam logic [5:0] CNT_RST = 6'h00;
    localparam logic [NCO_BITS-1:0] NCO_RST = 32'h0000_0000;
    localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;

    typedef enum logic [3:0] {
        DASP_FS_8K = 4'h0,
        DASP_FS_11K025 = 4'h1,
        DASP_FS_12K = 4'h2,
        DASP_FS_16K = 4'h3,
        DASP_FS_22K05 = 4'h4,
        DASP_FS_24K = 4'h5,
        DASP_FS_32K = 4'h6,
        DASP_FS_44K1 = 4'h7,
        DASP_FS_48K = 4'h8
    } dasp_rate_t;

    function automatic int dasp_rate_hz(input dasp_rate_t r);
        case (r)
            DASP_FS_8K: return 8000;
            DASP_FS_11K025: return 11025;
            DASP_FS_12K: return 12000;
            DASP_FS_16K: return 16000;
            DASP_FS_22K05: return 22050;
            DASP_FS_24K: return 24000;
            DASP_FS_32K: return 32000;
            DASP_FS_44K1: return 44100;
            default: return 48000;
        endcase
    endfunction

    // phase step giving two ticks per bit-clock period
    function automatic logic [NCO_BITS-1:0] dasp_nco_inc(
        input dasp_rate_t r, input logic [5:0] len);
        logic [63:0] num;
        num = (64'(dasp_rate_hz(r)) * 64'(len) * 64'h2) << NCO_BITS;
        return NCO_BITS'(num / 64'(CLK_HZ));
    endfunction
endpackage

// File: sim/dasp_codec_model.sv
// codec-side partner: bit clock and sync in slave role, data both ways
`timescale 1ns/1ps
module dasp_codec_model (
    input wire logic lead,
    input wire logic normal,
    input wire logic sync_two,
    input wire logic dual,
    input wire logic bclk,
    input wire logic wsync,
    input wire logic sdo,
    input wire logic [15:0] word,
    output logic gen_clk,
    output logic gen_sync,
    output logic sdi,
    output logic took,
    output logic [15:0] cap,
    output logic cap_stb
);
    int k = 0;
    int kn = 0;
    int g = 0;
    int b = -1;
    int c = -1;
    logic ps = 1'b0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] cs = 16'h0000;
    initial {gen_clk, gen_sync, sdi, took, cap_stb, cap} = '0;
    function automatic logic start(input int i);
        if (normal) return i == 0 || (dual && i == 16);
        return i == (sync_two ? 2 : 1);
    endfunction
    // clock runs free while this side leads, as a codec clock does
    always begin
        gen_clk = 1'b0;
        wait (lead);
        #62.5 gen_clk = 1'b1;
        #62.5 gen_clk = 1'b0;
        g = (g + 1) % (normal ? 32 : (sync_two ? 18 : 17));
        gen_sync = normal ? (g < 16) : (g < (sync_two ? 2 : 1));
    end
    // settle 2 ns so the sync launched on this fall is seen
    always @(negedge bclk) begin
        #2;
        kn = (wsync && !ps) ? 0 : k + 1;
        if (start(kn)) begin
            sh = word;
            b = 0;
            took = ~took;
        end else if (b >= 0 && b < 15) b++;
        else b = -1;
        sdi = (b >= 0) ? sh[15 - b] : ~sdi;
    end
    always @(posedge bclk) begin
        k = (wsync && !ps) ? 0 : k + 1;
        ps = wsync;
        if (start(k)) c = 0;
        if (c >= 0) begin
            cs = {cs[14:0], sdo};
            c++;
        end
        if (c == 16) begin
            cap = cs;
            cap_stb = ~cap_stb;
            c = -1;
        end
    end
endmodule

// File: sim/tb_dasp_port.sv
// self-checking bench: rate sweep and word loopback through a codec
`timescale 1ns/1ps
module tb_dasp_port;
    import dasp_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_master = 1'b1;
    logic cfg_normal_mode = 1'b0;
    logic cfg_sync_two = 1'b0;
    logic cfg_dual_mono = 1'b0;
    dasp_rate_t cfg_rate = DASP_FS_48K;
    logic [15:0] tx_data = 16'h0000;
    logic tx_valid = 1'b0;
    logic tx_ready, rx_valid, rx_chan, tx_underrun, sdo, sdi, bco, bcoe;
    logic wso, wsoe, gclk, gsync, took, cstb, bclk_w, wsync_w;
    logic [15:0] rx_data, cap;
    logic [15:0] mword = 16'h1234;
    logic [31:0] rng = 32'h0000_000a;
    logic [15:0] exp_tx[$];
    logic [15:0] exp_rx[$];
    logic exp_ch[$];
    int urn = 0;
    logic armed = 1'b0;
    logic sp = 1'b0;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int fr = -1000;
    int hi = 0;
    int rxn = 0;
    int refused = 0;
    int hz[9] = '{8000, 11025, 12000, 16000, 22050, 24000, 32000, 44100,
        48000};
    assign bclk_w = bcoe ? bco : gclk;
    assign wsync_w = wsoe ? wso : gsync;
    always #4 clock = ~clock;
    dasp_port u_dut (.clock(clock), .sys_rst(sys_rst),
        .cfg_master(cfg_master), .cfg_normal_mode(cfg_normal_mode),
        .cfg_sync_two(cfg_sync_two), .cfg_dual_mono(cfg_dual_mono),
        .cfg_rate(cfg_rate), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_chan(rx_chan), .tx_underrun(tx_underrun),
        .serial_data_out(sdo), .serial_data_in(sdi), .bit_clk_i(bclk_w),
        .bit_clk_o(bco), .bit_clk_oe(bcoe), .word_align_sync_i(wsync_w),
        .word_align_sync_o(wso), .word_align_sync_oe(wsoe));
    dasp_codec_model u_codec (.lead(~cfg_master), .normal(cfg_normal_mode),
        .sync_two(cfg_sync_two), .dual(cfg_dual_mono), .bclk(bclk_w),
        .wsync(wsync_w), .sdo(sdo), .word(mword), .gen_clk(gclk),
        .gen_sync(gsync), .sdi(sdi), .took(took), .cap(cap),
        .cap_stb(cstb));
    function automatic logic [15:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        // zero is what an underrun sends, so keep it out of the traffic
        return (rng[15:0] == 16'h0000) ? 16'h8000 : rng[15:0];
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ceiling: sweep plus four data runs come to about 60k cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 99000) begin
            failures++;
            tally_and_finish();
        end
    end
    // a word that starts at bit 16 belongs to the second half of the frame
    always @(took) begin
        if (armed) begin
            exp_rx.push_back(mword);
            exp_ch.push_back(cfg_normal_mode && u_codec.kn == 16);
        end
        mword = rnd();
    end
    always @(posedge clock) begin
        if (armed && tx_underrun === 1'b1) urn++;
        if (armed && rx_valid === 1'b1 && exp_rx.size() > 0) begin
            rxn++;
            check(rx_data, exp_rx.pop_front());
            check(16'(rx_chan), 16'(exp_ch.pop_front()));
        end
    end
    always @(cstb) begin
        if (armed && cap !== 16'h0000 && exp_tx.size() > 0) begin
            check(cap, exp_tx.pop_front());
        end
    end
    always @(posedge bclk_w) begin
        if (wsync_w && !sp && armed && cfg_master) begin
            if (fr > 0) begin
                check(16'(fr),
                    16'(cfg_normal_mode ? 32 : 17 + cfg_sync_two));
                check(16'(hi),
                    16'(cfg_normal_mode ? 16 : 1 + cfg_sync_two));
            end
            fr = 0;
            hi = 0;
        end
        fr++;
        if (wsync_w) hi++;
        sp = wsync_w;
    end
    task automatic setup(input logic m, n, s2, dm, input dasp_rate_t r);
        @(posedge clock);
        #1;
        armed = 1'b0;
        sys_rst = 1'b1;
        {cfg_master, cfg_normal_mode, cfg_sync_two, cfg_dual_mono} =
            {m, n, s2, dm};
        cfg_rate = r;
        fr = -1000;
        exp_tx.delete();
        exp_rx.delete();
        exp_ch.delete();
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 1'b0;
    endtask
    task automatic send(input logic [15:0] w);
        tx_data = w;
        tx_valid = 1'b1;
        @(posedge clock);
        while (tx_ready !== 1'b1) begin
            refused++;
            @(posedge clock);
        end
        exp_tx.push_back(w);
        #1;
    endtask
    task automatic rate_probe(input int r);
        int t0;
        int e;
        e = 4 * CLK_HZ / ((r[0] ? 18 : 17) * hz[r]);
        repeat (2) @(posedge bco);
        t0 = cyc;
        repeat (4) @(posedge bco);
        check(16'(bcoe & wsoe), 16'h0001);
        check(16'((cyc - t0 - e) inside {[-2:2]}), 16'h0001);
        $display("rate test %0d Hz done", hz[r]);
    endtask
    task automatic run_data(input logic m, n, s2, dm);
        setup(m, n, s2, dm, DASP_FS_48K);
        repeat (2) @(posedge wsync_w);
        armed = 1'b1;
        rxn = 0;
        urn = 0;
        refused = 0;
        @(posedge clock);
        #1;
        for (int i = 0; i < 5; i++) send(rnd());
        tx_valid = 1'b0;
        while (exp_tx.size() > 0) @(posedge clock);
        repeat (2) @(posedge wsync_w);
        check(16'(refused > 0), 16'h0001);
        check(16'(rxn > 1), 16'h0001);
        // the fifo runs dry at the end, so a word start must report it
        check(16'(urn > 0), 16'h0001);
        check(16'(bcoe), 16'(m));
        $display("data test master=%0d normal=%0d done", m, n);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        for (int r = 0; r < 9; r++) begin
            setup(1'b1, 1'b0, r[0], 1'b0, dasp_rate_t'(r));
            rate_probe(r);
        end
        run_data(1'b1, 1'b1, 1'b0, 1'b1);
        run_data(1'b1, 1'b0, 1'b1, 1'b0);
        run_data(1'b0, 1'b1, 1'b0, 1'b0);
        run_data(1'b0, 1'b0, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule
